// >>> tfp_top.sv
// Two-channel timer status, interrupt enable and PWM level registers on the 8-bit CPU path.
//
// How it works
// - Reserved upper bits always read as one.
// - Underflow flag sets on channel 1 underflow.
// - Overflow flag clears by read-one then write-zero.
// - Overflow flag sets on counter overflow.
// - Match flags set on compare match.
// - Match flags set on input capture.
// - Match flags clear by read-one then write-zero.
// - Interrupt raised only when flag and enable set.
// - Overflow enable gates overflow-or-underflow interrupt.
// - Enables 3..0 gate match interrupts D..A.
// - Polarity bits select PWM pin active level.
// - Level zero: match B clears, A sets.
// - Registers duplicated, one copy per channel.
// - Counter and general registers take words only.
// - Other registers are 8-bit on 8-bit path.
`default_nettype none
module tfp_top #(
    parameter int NUM_CH = tfp_pkg::NUM_CH
) (
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    input  wire tfp_pkg::tfp_access_t     cpu_acc,
    input  wire tfp_pkg::tfp_event_t [1:0] ch_event,
    output logic [7:0]                    cpu_rdata,
    output tfp_pkg::tfp_irq_t [1:0]       ch_irq,
    output logic [1:0][2:0]               timer_pin_bcd
);
    // Top-level state: read data and registered interrupt outputs.
    typedef struct packed {
        logic [7:0]                 rdata;
        tfp_pkg::tfp_irq_t [1:0]    irq;
    } tfp_top_state_t;

    tfp_top_state_t     st_reg;
    tfp_top_state_t     st_next;
    logic [1:0][5:0]    status_q;
    logic [1:0][4:0]    enable_q;
    logic [1:0][2:0]    level_q;
    logic [1:0][2:0]    pin_q;
    logic [1:0]         sel_status;
    logic [1:0]         sel_enable;
    logic [1:0]         sel_level;
    tfp_pkg::tfp_event_t [1:0] ev_fix;

    // Only byte-wide registers sit on this path; the word-wide counter and general registers live elsewhere.
    assign sel_status[0] = cpu_acc.idx == tfp_pkg::IDX_STATUS_0;
    assign sel_enable[0] = cpu_acc.idx == tfp_pkg::IDX_ENABLE_0;
    assign sel_level[0]  = cpu_acc.idx == tfp_pkg::IDX_LEVEL_0;
    assign sel_status[1] = cpu_acc.idx == tfp_pkg::IDX_STATUS_1;
    assign sel_enable[1] = cpu_acc.idx == tfp_pkg::IDX_ENABLE_1;
    assign sel_level[1]  = cpu_acc.idx == tfp_pkg::IDX_LEVEL_1;

    // Only channel 1 has a down-counting mode, so channel 0 never sees underflow.
    always_comb begin
        ev_fix = ch_event;
        ev_fix[0].underflow = 1'b0;
    end

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            tfp_channel u_ch (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .ev        (ev_fix[c]),
                .status_rd (cpu_acc.rd && sel_status[c]),
                .status_wr (cpu_acc.wr && sel_status[c]),
                .enable_wr (cpu_acc.wr && sel_enable[c]),
                .level_wr  (cpu_acc.wr && sel_level[c]),
                .wdata     (cpu_acc.wdata),
                .status_q  (status_q[c]),
                .enable_q  (enable_q[c]),
                .level_q   (level_q[c]),
                .pwm_pin_q (pin_q[c])
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        // Read data holds until the next read; unmapped indices read zero.
        if (cpu_acc.rd) begin
            st_next.rdata = 8'h00;
            for (int c = 0; c < 2; c++) begin
                if (sel_status[c]) begin
                    st_next.rdata = tfp_pkg::STATUS_RSVD | {2'b00, status_q[c]};
                end
                if (sel_enable[c]) begin
                    st_next.rdata = tfp_pkg::ENABLE_RSVD | {3'b000, enable_q[c]};
                end
                if (sel_level[c]) begin
                    st_next.rdata = tfp_pkg::LEVEL_RSVD | {5'b00000, level_q[c]};
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            st_next.irq[c].overflow_irq = enable_q[c][tfp_pkg::BIT_OVERFLOW_IRQ_EN] &&
                (status_q[c][tfp_pkg::BIT_OVF] || status_q[c][tfp_pkg::BIT_UDF]);
            st_next.irq[c].match_irq = enable_q[c][3:0] & status_q[c][3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cpu_rdata     = st_reg.rdata;
    assign ch_irq        = st_reg.irq;
    assign timer_pin_bcd = pin_q;

    chk_irq_gated: assert property (@(posedge sys_clk) disable iff (reset)
        (enable_q[0][0] == 1'b0) |=> !ch_irq[0].match_irq[0]) else $error("match irq A without enable");
    chk_irq_follows: assert property (@(posedge sys_clk) disable iff (reset)
        (enable_q[1][3] && status_q[1][3]) |=> ch_irq[1].match_irq[3]) else $error("match irq D missing");
    chk_ovf_shared: assert property (@(posedge sys_clk) disable iff (reset)
        (enable_q[1][tfp_pkg::BIT_OVERFLOW_IRQ_EN] && status_q[1][tfp_pkg::BIT_UDF]) |=> ch_irq[1].overflow_irq)
        else $error("underflow not on overflow irq");
    chk_rsvd_status: assert property (@(posedge sys_clk) disable iff (reset)
        (cpu_acc.rd && sel_status[0]) |=> (cpu_rdata[7:6] == 2'b11)) else $error("status reserved bits not one");
    chk_rsvd_level: assert property (@(posedge sys_clk) disable iff (reset)
        (cpu_acc.rd && sel_level[1]) |=> (cpu_rdata[7:3] == 5'h1F)) else $error("level reserved bits not one");
    chk_no_udf_ch0: assert property (@(posedge sys_clk) disable iff (reset)
        ch_event[0].underflow && !status_q[0][tfp_pkg::BIT_UDF] |=> !status_q[0][tfp_pkg::BIT_UDF])
        else $error("channel 0 underflow flag set");

    cov_ovf_irq: cover property (@(posedge sys_clk) disable iff (reset) ch_irq[0].overflow_irq);
    cov_match_clear: cover property (@(posedge sys_clk) disable iff (reset)
        status_q[0][0] ##1 !status_q[0][0]);
    cov_pwm_pin: cover property (@(posedge sys_clk) disable iff (reset) $rose(timer_pin_bcd[0][0]));
    cov_match_d_irq: cover property (@(posedge sys_clk) disable iff (reset) ch_irq[1].match_irq[3]);

    // Indices 3 and 7 hold nothing; a read there must not leak the previous read data.
    chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (reset)
        (cpu_acc.rd && !(|sel_status) && !(|sel_enable) && !(|sel_level)) |=> (cpu_rdata == 8'h00))
        else $error("unmapped index read not zero");

    // The same checks for every channel copy.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
        chk_ovf_irq_gate: assert property (@(posedge sys_clk) disable iff (reset)
            !enable_q[c][tfp_pkg::BIT_OVERFLOW_IRQ_EN] |=> !ch_irq[c].overflow_irq)
            else $error("overflow irq without enable");
        chk_ovf_irq_src: assert property (@(posedge sys_clk) disable iff (reset)
            (enable_q[c][tfp_pkg::BIT_OVERFLOW_IRQ_EN] && status_q[c][tfp_pkg::BIT_OVF]) |=> ch_irq[c].overflow_irq)
            else $error("overflow flag not on overflow irq");
        chk_match_quiet: assert property (@(posedge sys_clk) disable iff (reset)
            (status_q[c][3:0] == 4'h0) |=> (ch_irq[c].match_irq == 4'h0))
            else $error("match irq without flag");
        chk_rsvd_enable: assert property (@(posedge sys_clk) disable iff (reset)
            (cpu_acc.rd && sel_enable[c]) |=> (cpu_rdata[7:5] == 3'h7))
            else $error("enable reserved bits not one");
        chk_level_read: assert property (@(posedge sys_clk) disable iff (reset)
            (cpu_acc.rd && sel_level[c]) |=> (cpu_rdata[2:0] == $past(level_q[c])))
            else $error("level bits read back wrong");
    end
endmodule
`default_nettype wire

// >>> tfp_pkg.sv
// Package with register offsets, field positions and carrier types for the timer flag block.
`default_nettype none
package tfp_pkg;
    localparam int NUM_CH = 2;
    // Register indices on the internal 8-bit register path.
    localparam logic [2:0] IDX_STATUS_0 = 3'h0;
    localparam logic [2:0] IDX_ENABLE_0 = 3'h1;
    localparam logic [2:0] IDX_LEVEL_0  = 3'h2;
    localparam logic [2:0] IDX_STATUS_1 = 3'h4;
    localparam logic [2:0] IDX_ENABLE_1 = 3'h5;
    localparam logic [2:0] IDX_LEVEL_1  = 3'h6;
    // Field positions.
    localparam int BIT_UDF = 5;
    localparam int BIT_OVF = 4;
    localparam int BIT_OVERFLOW_IRQ_EN = 4;
    // Reserved bits that always read as one.
    localparam logic [7:0] STATUS_RSVD = 8'hC0;
    localparam logic [7:0] ENABLE_RSVD = 8'hE0;
    localparam logic [7:0] LEVEL_RSVD  = 8'hF8;
    localparam logic [5:0] STATUS_RESET = 6'h00;
    localparam logic [4:0] ENABLE_RESET = 5'h00;
    localparam logic [2:0] LEVEL_RESET  = 3'h0;

    // Per-channel hardware events, one cycle pulses except the pwm_mode level.
    typedef struct packed {
        logic       overflow;
        logic       underflow;
        logic [3:0] match;     // D..A, compare match or input capture
        logic       pwm_mode;
        logic [3:0] cm_pulse;  // D..A compare match for PWM waveform
    } tfp_event_t;

    // Per-channel interrupt requests.
    typedef struct packed {
        logic       overflow_irq;
        logic [3:0] match_irq;  // D..A
    } tfp_irq_t;

    // One CPU access on the 8-bit register path.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] idx;
        logic [7:0] wdata;
    } tfp_access_t;
endpackage
`default_nettype wire

// >>> tfp_channel.sv
// One timer channel: status flags, interrupt enables, PWM level and PWM pin logic.
`default_nettype none
module tfp_channel (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire tfp_pkg::tfp_event_t ev,
    input  wire logic                status_rd,
    input  wire logic                status_wr,
    input  wire logic                enable_wr,
    input  wire logic                level_wr,
    input  wire logic [7:0]          wdata,
    output logic [5:0]               status_q,
    output logic [4:0]               enable_q,
    output logic [2:0]               level_q,
    output logic [2:0]               pwm_pin_q
);
    typedef struct packed {
        logic [5:0] flags;
        logic [5:0] armed;
        logic [4:0] enable;
        logic [2:0] level;
        logic [2:0] pins;
    } tfp_ch_state_t;

    tfp_ch_state_t st_reg;
    tfp_ch_state_t st_next;
    logic [5:0]    set_ev;

    always_comb begin
        st_next = st_reg;
        set_ev = {ev.underflow, ev.overflow, ev.match};
        for (int i = 0; i < 6; i++) begin
            // A clear needs a prior read as one; writing one changes nothing.
            if (status_wr && !wdata[i] && st_reg.armed[i]) begin
                st_next.flags[i] = 1'b0;
                st_next.armed[i] = 1'b0;
            end
            if (status_rd && st_reg.flags[i]) begin
                st_next.armed[i] = 1'b1;
            end
            // Set wins over a simultaneous clear.
            if (set_ev[i]) begin
                st_next.flags[i] = 1'b1;
            end
        end
        if (enable_wr) begin
            st_next.enable = wdata[4:0];
        end
        if (level_wr) begin
            st_next.level = wdata[2:0];
        end
        // Pin x in B..D takes its level bit on its own match and the inverse on match A.
        if (ev.pwm_mode) begin
            for (int p = 0; p < 3; p++) begin
                if (ev.cm_pulse[p + 1]) begin
                    st_next.pins[p] = st_reg.level[p];
                end else if (ev.cm_pulse[0]) begin
                    st_next.pins[p] = ~st_reg.level[p];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '{flags: tfp_pkg::STATUS_RESET, armed: 6'h00, enable: tfp_pkg::ENABLE_RESET,
                        level: tfp_pkg::LEVEL_RESET, pins: 3'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign status_q  = st_reg.flags;
    assign enable_q  = st_reg.enable;
    assign level_q   = st_reg.level;
    assign pwm_pin_q = st_reg.pins;

    chk_flag_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
        ev.overflow |=> st_reg.flags[tfp_pkg::BIT_OVF]) else $error("overflow event lost");
    chk_clear_needs_read: assert property (@(posedge sys_clk) disable iff (reset)
        (st_reg.flags[0] && !st_reg.armed[0] && !status_rd) |=> st_reg.flags[0])
        else $error("match flag A cleared without prior read");
    chk_write_one_keeps: assert property (@(posedge sys_clk) disable iff (reset)
        (st_reg.flags[tfp_pkg::BIT_OVF] && status_wr && wdata[tfp_pkg::BIT_OVF]) |=> st_reg.flags[tfp_pkg::BIT_OVF])
        else $error("overflow flag changed by writing one");
    chk_udf_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (st_reg.armed[tfp_pkg::BIT_UDF] && status_wr && !wdata[tfp_pkg::BIT_UDF] && !ev.underflow)
        |=> !st_reg.flags[tfp_pkg::BIT_UDF]) else $error("underflow flag not cleared");
    chk_pwm_level_b: assert property (@(posedge sys_clk) disable iff (reset)
        (ev.pwm_mode && ev.cm_pulse[1]) |=> (st_reg.pins[0] == $past(st_reg.level[0])))
        else $error("pin B wrong level on match B");
endmodule
`default_nettype wire

// >>> tfp_cpu_model.sv
// Behavioural CPU model that issues single 8-bit register transfers.
`default_nettype none
module tfp_cpu_model (
    input  wire logic                sys_clk,
    input  wire logic [7:0]          cpu_rdata,
    output var tfp_pkg::tfp_access_t cpu_acc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cpu_acc = '0;
    // The word-wide counter registers are not behind this path, so only bytes are sent.
    task automatic access(input logic r, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        cpu_acc <= '{rd: r, wr: !r, idx: a, wdata: d};
        @(posedge sys_clk);
        // Released fields show the inverse so stale values are never mistaken for live ones.
        cpu_acc <= '{rd: 1'b0, wr: 1'b0, idx: ~a, wdata: ~d};
        @(posedge sys_clk);
        #1 q = cpu_rdata;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the two-channel timer flag block.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      sys_clk;
    logic                      reset;
    tfp_pkg::tfp_access_t      cpu_acc;
    tfp_pkg::tfp_event_t [1:0] ch_event;
    logic [7:0]                cpu_rdata;
    tfp_pkg::tfp_irq_t [1:0]   ch_irq;
    logic [1:0][2:0]           timer_pin_bcd;
    int                        err_count;
    int                        n_checks;
    logic [5:0]                st_exp [2];
    logic [5:0]                arm [2];
    logic [4:0]                en_exp [2];
    logic [7:0]                q;
    logic [2:0]                lv;
    logic [2:0]                pin_exp;

    tfp_top dut_u (.sys_clk(sys_clk), .reset(reset), .cpu_acc(cpu_acc), .ch_event(ch_event),
                   .cpu_rdata(cpu_rdata), .ch_irq(ch_irq), .timer_pin_bcd(timer_pin_bcd));
    tfp_cpu_model cpu_u (.sys_clk(sys_clk), .cpu_rdata(cpu_rdata), .cpu_acc(cpu_acc));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic bump(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_reg(input logic [2:0] a, input logic [7:0] e);
        cpu_u.access(1'b1, a, 8'h00, q);
        bump("register", e, q);
    endtask
    task automatic cmp_irq(input int ch);
        logic [4:0] e;
        e = {en_exp[ch][4] & (st_exp[ch][5] | st_exp[ch][4]), en_exp[ch][3:0] & st_exp[ch][3:0]};
        @(posedge sys_clk);
        #1 bump("irq", 8'(e), 8'({ch_irq[ch].overflow_irq, ch_irq[ch].match_irq}));
    endtask
    task automatic cmp_pin(input int ch);
        bump("pin", 8'(pin_exp), 8'(timer_pin_bcd[ch]));
    endtask
    task automatic rd_status(input int ch);
        cmp_reg(3'(ch * 4), {2'b11, st_exp[ch]});
        arm[ch] = arm[ch] | st_exp[ch];
    endtask
    task automatic wr_status(input int ch, input logic [7:0] d);
        cpu_u.access(1'b0, 3'(ch * 4), d, q);
        st_exp[ch] = st_exp[ch] & ~(arm[ch] & ~d[5:0]);
        // Only a clearing write disarms a bit; writing one keeps the earlier read in force.
        arm[ch] = arm[ch] & d[5:0];
    endtask
    task automatic pulse(input int ch, input tfp_pkg::tfp_event_t e);
        @(posedge sys_clk);
        ch_event[ch] <= e;
        @(posedge sys_clk);
        ch_event[ch] <= tfp_pkg::tfp_event_t'(e & 11'h010);
        repeat (2) @(posedge sys_clk);
        #1 st_exp[ch] = st_exp[ch] | {e.underflow & (ch == 1), e.overflow, e.match};
    endtask
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        tfp_pkg::tfp_event_t e;
        void'($urandom(51));
        reset = 1'b1;
        ch_event = '0;
        err_count = 0;
        n_checks = 0;
        st_exp = '{6'h00, 6'h00};
        arm = '{6'h00, 6'h00};
        en_exp = '{5'h00, 5'h00};
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        cpu_u.access(1'b0, 3'h3, 8'hFF, q);
        for (int a = 0; a < 8; a++) begin
            cmp_reg(3'(a), a[1:0] == 2'h0 ? 8'hC0 : a[1:0] == 2'h1 ? 8'hE0 : a[1:0] == 2'h2 ? 8'hF8 : 8'h00);
        end
        for (int ch = 0; ch < 2; ch++) begin
            e = '0;
            e.overflow = 1'b1;
            e.underflow = 1'b1;
            e.match = 4'($urandom);
            pulse(ch, e);
            cmp_irq(ch);
            rd_status(ch);
            rd_status(1 - ch);
            en_exp[ch] = 5'($urandom);
            cpu_u.access(1'b0, 3'(ch * 4 + 1), {3'b000, en_exp[ch]}, q);
            cmp_reg(3'(ch * 4 + 1), {3'b111, en_exp[ch]});
            cmp_irq(ch);
            wr_status(ch, 8'($urandom));
            rd_status(ch);
            cmp_irq(ch);
            wr_status(ch, 8'h00);
            cmp_irq(ch);
            e.match = 4'hF;
            pulse(ch, e);
            wr_status(ch, 8'h00);
            rd_status(ch);
            wr_status(ch, 8'h00);
            rd_status(ch);
            pulse(ch, e);
            rd_status(ch);
            fork
                pulse(ch, e);
                wr_status(ch, 8'h00);
            join
            rd_status(ch);
            wr_status(ch, 8'h00);
            cmp_irq(ch);
            lv = 3'($urandom);
            cpu_u.access(1'b0, 3'(ch * 4 + 2), {5'h00, lv}, q);
            cmp_reg(3'(ch * 4 + 2), {5'h1F, lv});
            e = '0;
            e.pwm_mode = 1'b1;
            for (int k = 0; k < 4; k++) begin
                e.cm_pulse = 4'(1 << k);
                pulse(ch, e);
                if (k == 0) pin_exp = ~lv;
                else pin_exp[k - 1] = lv[k - 1];
                cmp_pin(ch);
            end
        end
        // A reset in mid-run with a flag pending must bring the registers back; status 0, enable 1 and level 1 are read back to check.
        e = '0;
        e.overflow = 1'b1;
        pulse(0, e);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        st_exp = '{6'h00, 6'h00};
        arm = '{6'h00, 6'h00};
        en_exp = '{5'h00, 5'h00};
        pin_exp = 3'h0;
        cmp_irq(0);
        cmp_pin(1);
        cmp_reg(3'h0, 8'hC0);
        cmp_reg(3'h5, 8'hE0);
        cmp_reg(3'h6, 8'hF8);
        report_and_stop();
    end
endmodule
`default_nettype wire
